// [rtl/status_reporting.sv]
// Status reporting and service request block of a bus-programmable instrument.
// Assumes a message parser on core_clk gives one-cycle strobes for commands,
// queries and events; conflict flags come from outside and are synchronised.
`timescale 1ns/1ps
module status_reporting #(
    parameter longint OPC_DELAY = status_pkg::OPC_DELAY_CYCLES,
    parameter int CONFLICTS = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [CONFLICTS-1:0] conflict_in,
    input wire logic in_byte_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_byte_pop,
    input wire logic msg_terminator,
    input wire logic resp_push,
    input wire logic [7:0] resp_byte,
    input wire logic resp_end,
    input wire logic resp_pop,
    input wire logic status_query,
    input wire logic serial_poll,
    input wire logic rmask_write,
    input wire logic emask_write,
    input wire logic [7:0] write_data,
    input wire logic rmask_query,
    input wire logic latch_query,
    input wire logic emask_query,
    input wire logic conflict_query,
    input wire logic err_query,
    input wire logic opc_cmd,
    input wire logic opc_query,
    input wire logic cmd_error,
    input wire logic exec_error,
    input wire logic dev_error,
    input wire logic query_error,
    input wire logic err_push,
    input wire logic [15:0] err_code,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic [15:0] err_read,
    output logic [CONFLICTS-1:0] conflict_read,
    output logic srq,
    output logic in_ready,
    output logic [7:0] resp_head,
    output logic resp_avail,
    output logic opc_busy
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [CONFLICTS-1:0] conf_meta_ff;
    logic [CONFLICTS-1:0] conf_ff;

    // Reset is taken at once and released through two flip-flops.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // Conflict pins pass two flip-flops; each bit is its own level.
    genvar gi;
    generate
        for (gi = 0; gi < CONFLICTS; gi++) begin : g_conf_sync
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    conf_meta_ff[gi] <= 1'b0;
                    conf_ff[gi] <= 1'b0;
                end else begin
                    conf_meta_ff[gi] <= conflict_in[gi];
                    conf_ff[gi] <= conf_meta_ff[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Queues
    // ----------------------------------------------------------------
    logic in_full;
    logic out_empty;
    logic [8:0] out_head;
    logic [5:0] msg_count_ff;
    logic [5:0] nxt_msg_count;
    logic [15:0] err_head;
    wire resp_room = (msg_count_ff < 6'(status_pkg::OUT_QUEUE_MSGS));
    wire opc_resp;

    // Program bytes are buffered ahead of the parser.
    byte_queue #(.WIDTH(8), .DEPTH(status_pkg::IN_QUEUE_DEPTH)) u_in_queue (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flush(1'b0),
        .push(in_byte_valid),
        .push_data(in_byte),
        .pop(in_byte_pop),
        .pop_data(),
        .full(in_full),
        .empty()
    );

    // Response bytes carry an end-of-message mark in bit 8.
    wire out_push = (resp_push || opc_resp) && resp_room;
    wire [8:0] out_data = opc_resp ? {1'b1, status_pkg::ASCII_ONE} : {resp_end, resp_byte};
    wire out_pop = resp_pop && !out_empty;
    wire msg_in = out_push && out_data[8];
    wire msg_out = out_pop && out_head[8];

    byte_queue #(.WIDTH(9), .DEPTH(status_pkg::OUT_QUEUE_MSGS * 16)) u_out_queue (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flush(msg_terminator),
        .push(out_push),
        .push_data(out_data),
        .pop(out_pop),
        .pop_data(out_head),
        .full(),
        .empty(out_empty)
    );

    // Whole messages held; the terminator of a new program message drops them.
    assign nxt_msg_count = msg_terminator ? 6'h00
                         : msg_count_ff + 6'(msg_in) - 6'(msg_out);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) msg_count_ff <= 6'h00;
        else msg_count_ff <= nxt_msg_count;
    end

    error_queue #(.DEPTH(status_pkg::ERR_QUEUE_DEPTH)) u_err_queue (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .push(err_push),
        .push_code(err_code),
        .pop(err_query),
        .head_code(err_head),
        .empty()
    );

    // ----------------------------------------------------------------
    // Operation complete delay
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OPC_IDLE = 2'b01,
        OPC_WAIT = 2'b10
    } opc_state_t;
    opc_state_t opc_state_ff;
    logic [31:0] opc_cnt_ff;
    logic opc_is_query_ff;
    wire opc_start = (opc_cmd || opc_query) && (opc_state_ff == OPC_IDLE);
    wire opc_done = (opc_state_ff == OPC_WAIT) && (opc_cnt_ff == 32'h0000_0000);
    assign opc_resp = opc_done && opc_is_query_ff;
    wire opc_event = opc_done && !opc_is_query_ff;

    // Two-second wait before the event bit or the queued one appears.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            opc_state_ff <= OPC_IDLE;
            opc_cnt_ff <= 32'h0000_0000;
            opc_is_query_ff <= 1'b0;
        end else begin
            case (opc_state_ff)
                OPC_IDLE: begin
                    if (opc_start) begin
                        opc_state_ff <= OPC_WAIT;
                        opc_cnt_ff <= 32'(OPC_DELAY - 1);
                        opc_is_query_ff <= opc_query;
                    end
                end
                OPC_WAIT: begin
                    if (opc_done) opc_state_ff <= OPC_IDLE;
                    else opc_cnt_ff <= opc_cnt_ff - 32'h0000_0001;
                end
                default: opc_state_ff <= OPC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status registers
    // ----------------------------------------------------------------
    logic [7:0] rmask_ff;
    logic [7:0] emask_ff;
    logic [7:0] evt_ff;
    logic [7:0] nxt_evt;
    logic rqs_ff;
    logic hw_prev_ff;
    wire hw_now = |conf_ff;
    wire mav = (msg_count_ff != 6'h00);
    wire esb = |(evt_ff & emask_ff);
    wire [7:0] status_core = {2'b00, esb, mav, 3'b000, hw_now};
    wire mss = |(status_core & rmask_ff);
    wire hw_rise = hw_now && !hw_prev_ff && rmask_ff[status_pkg::STATUS_HW_BIT];
    wire [7:0] evt_set = {cmd_error ? 8'h20 : 8'h00} | {exec_error ? 8'h10 : 8'h00}
                       | {dev_error ? 8'h08 : 8'h00} | {query_error ? 8'h04 : 8'h00}
                       | {opc_event ? 8'h01 : 8'h00};

    // Latch clears on its query, but a new event in that cycle still lands.
    assign nxt_evt = ((latch_query ? 8'h00 : evt_ff) | evt_set)
                   & status_pkg::EVT_USED_MASK;

    // Enable masks, event latch and previous hardware level.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rmask_ff <= status_pkg::RMASK_RESET;
            emask_ff <= status_pkg::EMASK_RESET;
            evt_ff <= status_pkg::EVT_RESET;
            hw_prev_ff <= 1'b0;
        end else begin
            if (rmask_write) rmask_ff <= write_data & status_pkg::RMASK_WRITE_MASK;
            if (emask_write) begin
                emask_ff <= write_data & status_pkg::EVT_USED_MASK;
            end
            evt_ff <= nxt_evt;
            hw_prev_ff <= hw_now;
        end
    end

    // Request flag: set on new request when none pends, cleared only by poll.
    wire rqs_new = hw_rise && !rqs_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) rqs_ff <= 1'b0;
        else if (rqs_new) rqs_ff <= 1'b1;
        else if (serial_poll) rqs_ff <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Read-back and outputs
    // ----------------------------------------------------------------
    wire [7:0] status_query_val = status_core | {1'b0, mss, 6'h00};
    wire [7:0] status_poll_val = status_core | {1'b0, rqs_ff, 6'h00};
    wire any_read = status_query || serial_poll || rmask_query || latch_query || emask_query;
    wire [7:0] rd_sel = serial_poll ? status_poll_val
                      : status_query ? status_query_val
                      : rmask_query ? rmask_ff
                      : latch_query ? evt_ff
                      : emask_query ? emask_ff : 8'h00;

    // All outputs are registered.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= 8'h00;
            read_valid <= 1'b0;
            err_read <= 16'h0000;
            conflict_read <= '0;
            srq <= 1'b0;
            in_ready <= 1'b0;
            resp_head <= 8'h00;
            resp_avail <= 1'b0;
            opc_busy <= 1'b0;
        end else begin
            read_data <= rd_sel;
            read_valid <= any_read;
            if (err_query) err_read <= err_head;
            if (conflict_query) conflict_read <= conf_ff;
            srq <= rqs_ff || rqs_new;
            in_ready <= !in_full;
            resp_head <= out_head[7:0];
            resp_avail <= !out_empty && !msg_terminator;
            opc_busy <= (opc_state_ff == OPC_WAIT);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_poll;
        serial_poll && !rqs_new;
    endsequence

    sequence s_hw_request;
        hw_rise && !rqs_ff;
    endsequence

    sequence s_status_read;
        status_query && !serial_poll && !rqs_new;
    endsequence

    a_poll_clears_rqs: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_poll |=> !rqs_ff) else $error("Serial poll did not clear request flag.");
    a_hw_bit_live: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_query |=> read_data[0] == $past(hw_now)) else $error("Hardware bit wrong.");
    a_srq_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        rqs_ff |=> srq) else $error("Service request output not following flag.");
    a_mav_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
        msg_terminator |=> !mav) else $error("Terminator did not clear message available.");
    a_latch_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        latch_query && evt_set == 8'h00 |=> evt_ff == 8'h00) else $error("Latch not cleared.");
    a_rmask_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rmask_ff & 8'hCE) == 8'h00) else $error("Enable mask holds reserved bits.");
    a_mss_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_query |=> read_data[6] == $past(mss)) else $error("Summary bit wrong on query.");
    a_opc_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
        opc_start |=> !opc_done) else $error("Operation complete came too early.");

    // An enabled conflict edge raises the request flag.
    a_rqs_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_hw_request |=> rqs_ff) else $error("Conflict raised no request.");

    // A serial poll returns the request flag in bit 6.
    a_poll_bit6: assert property (@(posedge core_clk) disable iff (!rst_n)
        serial_poll |=> read_data[6] == $past(rqs_ff)) else $error("Poll bit 6 wrong.");

    // A status query leaves the request flag as it was.
    a_query_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_status_read |=> rqs_ff == $past(rqs_ff)) else $error("Query changed request flag.");

    // Unused status bits read zero on both kinds of read.
    a_status_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        status_query || serial_poll |=> (read_data & 8'h8E) == 8'h00)
        else $error("Unused status bit set.");

    // A command error lands in its latch bit.
    a_cme_latched: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmd_error |=> evt_ff[status_pkg::EVT_CME_BIT]) else $error("Command error lost.");

    // Writing zero to the event mask clears every enable.
    a_emask_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        emask_write && write_data == 8'h00 |=> emask_ff == 8'h00) else $error("Mask not cleared.");

    // A stored message end raises message available.
    a_mav_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        msg_in && !msg_terminator |=> mav) else $error("Message available not set.");
endmodule : status_reporting

// [rtl/status_pkg.sv]
// Package of constants for the status reporting and service request block.
// Assumes nothing beyond a SystemVerilog compiler; the files that use it write package::name.
package status_pkg;
    // ----------------------------------------------------------------
    // Status byte fields
    // ----------------------------------------------------------------
    localparam int STATUS_HW_BIT = 0;
    localparam int STATUS_MAV_BIT = 4;
    localparam int STATUS_ESB_BIT = 5;
    localparam int STATUS_RQS_BIT = 6;
    localparam logic [7:0] STATUS_USED_MASK = 8'h31;
    localparam logic [7:0] RMASK_WRITE_MASK = 8'h31;
    // ----------------------------------------------------------------
    // Standard event latch fields
    // ----------------------------------------------------------------
    localparam int EVT_OPC_BIT = 0;
    localparam int EVT_QYE_BIT = 2;
    localparam int EVT_DDE_BIT = 3;
    localparam int EVT_EXE_BIT = 4;
    localparam int EVT_CME_BIT = 5;
    localparam int EVT_PON_BIT = 7;
    localparam logic [7:0] EVT_USED_MASK = 8'hBD;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RMASK_RESET = 8'h00;
    localparam logic [7:0] EMASK_RESET = 8'h00;
    localparam logic [7:0] EVT_RESET = 8'h80;
    // ----------------------------------------------------------------
    // Queue depths and codes
    // ----------------------------------------------------------------
    localparam int IN_QUEUE_DEPTH = 100;
    localparam int OUT_QUEUE_MSGS = 40;
    localparam int ERR_QUEUE_DEPTH = 10;
    localparam logic [15:0] ERR_TOO_MANY = 16'hFEA2;
    localparam logic [7:0] ASCII_ONE = 8'h31;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam longint OPC_DELAY_MS = 2000;
    localparam longint OPC_DELAY_CYCLES = CLK_HZ * OPC_DELAY_MS / 1000;
endpackage : status_pkg

// [rtl/byte_queue.sv]
// Plain FIFO with occupancy count, used for the input and output queues.
// Assumes a synchronous active-low reset copy from the top module.
`timescale 1ns/1ps
module byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 100
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW-1:0] count_ff;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;
    wire [AW-1:0] last = AW'(DEPTH - 1);

    // Status and head-of-queue outputs.
    assign full = (count_ff == AW'(DEPTH));
    assign empty = (count_ff == '0);
    assign pop_data = mem[rd_ptr_ff];

    // Storage array, no reset needed.
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= push_data;
        end
    end

    // Pointers and count; flush empties the queue at once.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (do_push) wr_ptr_ff <= (wr_ptr_ff == last) ? '0 : wr_ptr_ff + 1'b1;
            if (do_pop) rd_ptr_ff <= (rd_ptr_ff == last) ? '0 : rd_ptr_ff + 1'b1;
            count_ff <= count_ff + AW'(do_push) - AW'(do_pop);
        end
    end
endmodule : byte_queue

// [rtl/error_queue.sv]
// Ten-entry error code FIFO; on overflow the newest entry becomes the overflow code.
// Assumes a synchronous active-low reset copy from the top module.
`timescale 1ns/1ps
module error_queue #(
    parameter int DEPTH = 10
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [15:0] push_code,
    input wire logic pop,
    output logic [15:0] head_code,
    output logic empty
);
    localparam int AW = $clog2(DEPTH + 1);
    logic [15:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW-1:0] count_ff;
    wire full = (count_ff == AW'(DEPTH));
    wire do_pop = pop && !empty;
    wire do_push = push && (!full || do_pop);
    wire overlay = push && full && !do_pop;
    wire [AW-1:0] last = AW'(DEPTH - 1);
    wire [AW-1:0] newest = (wr_ptr_ff == '0) ? last : wr_ptr_ff - 1'b1;

    // Empty flag and head entry; an empty queue reads as code zero.
    assign empty = (count_ff == '0);
    assign head_code = empty ? 16'h0000 : mem[rd_ptr_ff];

    // Storage, with the overflow overlay on the newest slot.
    always_ff @(posedge core_clk) begin
        if (do_push) mem[wr_ptr_ff] <= push_code;
        else if (overlay) mem[newest] <= status_pkg::ERR_TOO_MANY;
    end

    // Pointers and occupancy.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (do_push) wr_ptr_ff <= (wr_ptr_ff == last) ? '0 : wr_ptr_ff + 1'b1;
            if (do_pop) rd_ptr_ff <= (rd_ptr_ff == last) ? '0 : rd_ptr_ff + 1'b1;
            count_ff <= count_ff + AW'(do_push) - AW'(do_pop);
        end
    end
endmodule : error_queue

// [dv/poll_controller.sv]
// Model of the remote controller that answers service requests by polling.
// Assumes strobes are launched at the falling edge of core_clk.
`timescale 1ns/1ps
module poll_controller #(
    parameter int DELAY = 3
) (
    input wire logic core_clk,
    input wire logic srq,
    input wire logic auto_en,
    output logic serial_poll
);
    int wait_cnt;

    initial begin
        serial_poll = 1'b0;
        wait_cnt = 0;
    end

    // Waits a few cycles with a request pending, then issues one serial poll.
    always @(negedge core_clk) begin
        serial_poll <= 1'b0;
        if (auto_en && srq === 1'b1 && !serial_poll) begin
            wait_cnt <= (wait_cnt == DELAY) ? 0 : wait_cnt + 1;
            if (wait_cnt == DELAY) begin
                serial_poll <= 1'b1;
            end
        end else begin
            wait_cnt <= 0;
        end
    end
endmodule : poll_controller

// [dv/status_reporting_bench.sv]
// Self-checking bench for the status reporting and service request block.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/1ps
module status_reporting_bench;
    logic core_clk, nrst, auto_en, in_byte_valid, in_byte_pop, msg_terminator;
    logic resp_push, resp_end, resp_pop, serial_poll, conflict_query, err_query;
    logic opc_cmd, opc_query, err_push, read_valid, srq, in_ready, resp_avail, opc_busy;
    logic [3:0] qs;
    logic [3:0] ev;
    logic [1:0] ws;
    logic [7:0] conflict_in, in_byte, resp_byte, write_data, read_data, resp_head;
    logic [7:0] conflict_read, d, seed;
    logic [15:0] err_code, err_read;
    int num_errors, comparisons, cycles, n;

    status_reporting #(.OPC_DELAY(20), .CONFLICTS(8)) status_reporting_inst (
        .core_clk(core_clk), .nrst(nrst), .conflict_in(conflict_in),
        .in_byte_valid(in_byte_valid), .in_byte(in_byte), .in_byte_pop(in_byte_pop),
        .msg_terminator(msg_terminator), .resp_push(resp_push), .resp_byte(resp_byte),
        .resp_end(resp_end), .resp_pop(resp_pop), .status_query(qs[0]),
        .serial_poll(serial_poll), .rmask_write(ws[0]), .emask_write(ws[1]),
        .write_data(write_data), .rmask_query(qs[1]), .latch_query(qs[2]),
        .emask_query(qs[3]),
        .conflict_query(conflict_query), .err_query(err_query), .opc_cmd(opc_cmd),
        .opc_query(opc_query), .cmd_error(ev[3]), .exec_error(ev[2]), .dev_error(ev[1]),
        .query_error(ev[0]), .err_push(err_push), .err_code(err_code),
        .read_data(read_data), .read_valid(read_valid), .err_read(err_read),
        .conflict_read(conflict_read), .srq(srq), .in_ready(in_ready),
        .resp_head(resp_head), .resp_avail(resp_avail), .opc_busy(opc_busy));

    poll_controller #(.DELAY(3)) poll_controller_inst (
        .core_clk(core_clk), .srq(srq), .auto_en(auto_en), .serial_poll(serial_poll));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Expected status byte from its live fields; the unused bits stay zero.
    function automatic logic [7:0] sbyte(input logic hw, mav, esb, b6);
        return {1'b0, b6, esb, mav, 3'b000, hw};
    endfunction : sbyte

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // Pulses one query strobe and waits a bounded time for the answer.
    task automatic query(input int k, output logic [7:0] v);
        @(negedge core_clk) qs[k] = 1'b1;
        @(negedge core_clk) qs[k] = 1'b0;
        n = 0;
        while (read_valid !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        v = read_data;
    endtask : query

    task automatic wr(input int k, input logic [7:0] v);
        @(negedge core_clk) ws[k] = 1'b1;
        write_data = v;
        @(negedge core_clk) ws[k] = 1'b0;
    endtask : wr

    task automatic give_verdict();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Clock of 40 ns and a cycle ceiling that cuts a hang short.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {nrst, auto_en, in_byte_valid, in_byte_pop, msg_terminator} = '0;
        {resp_push, resp_end, resp_pop, conflict_query, err_query} = '0;
        {opc_cmd, opc_query, err_push, qs, ev, ws} = '0;
        {conflict_in, in_byte, resp_byte, write_data, err_code} = '0;
        seed = 8'h27;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        query(2, d); check(d, 8'h80);
        query(2, d); check(d, 8'h00);
        query(1, d); check(d, 8'h00);
        query(3, d); check(d, 8'h00);
        $display("test reset values done");
        wr(0, 8'hFF); query(1, d); check(d, 8'h31);
        seed = lfsr(seed);
        wr(1, seed); query(3, d); check(d, seed & 8'hBD);
        wr(1, 8'h00); query(3, d); check(d, 8'h00);
        $display("test masks done");
        // A random conflict raises a request that the controller polls away.
        seed = lfsr(seed);
        conflict_in = seed | 8'h01;
        n = 0;
        while (srq !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        check(srq, 1'b1);
        @(negedge core_clk) conflict_query = 1'b1;
        @(negedge core_clk) conflict_query = 1'b0;
        @(negedge core_clk); check(conflict_read, conflict_in);
        query(0, d); check(d, sbyte(1, 0, 0, 1));
        auto_en = 1'b1;
        @(negedge core_clk);
        n = 0;
        while (read_valid !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check(read_data, sbyte(1, 0, 0, 1));
        auto_en = 1'b0;
        repeat (2) @(negedge core_clk);
        check(srq, 1'b0);
        query(0, d); check(d, sbyte(1, 0, 0, 1));
        wr(0, 8'h30); query(0, d); check(d, sbyte(1, 0, 0, 0));
        conflict_in = 8'h00;
        repeat (4) @(negedge core_clk);
        query(0, d); check(d, 8'h00);
        wr(0, 8'h31);
        $display("test conflict and poll done");
        // Enabled event sets the summary; a masked one still lands in the latch.
        wr(1, 8'h20);
        @(negedge core_clk) ev = 4'h8;
        @(negedge core_clk) ev = 4'h4;
        @(negedge core_clk) ev = 4'h0;
        query(0, d); check(d, sbyte(0, 0, 1, 1));
        query(2, d); check(d, 8'h30);
        query(0, d); check(d, 8'h00);
        $display("test events done");
        // A whole response message sets message available until a terminator.
        @(negedge core_clk) {resp_push, resp_end} = 2'b11;
        resp_byte = seed;
        @(negedge core_clk) {resp_push, resp_end} = 2'b00;
        query(0, d); check(d, sbyte(0, 1, 0, 1));
        query(0, d); check(d, sbyte(0, 1, 0, 1));
        check(resp_avail, 1'b1);
        check(resp_head, seed);
        @(negedge core_clk) msg_terminator = 1'b1;
        @(negedge core_clk) msg_terminator = 1'b0;
        query(0, d); check(d, 8'h00);
        check(resp_avail, 1'b0);
        $display("test message available done");
        // Eleven errors overflow the queue; the tenth entry reads the overflow code.
        for (int i = 0; i < 11; i++) begin
            @(negedge core_clk) err_push = 1'b1;
            err_code = 16'(i + 1);
        end
        @(negedge core_clk) err_push = 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(negedge core_clk) err_query = 1'b1;
            @(negedge core_clk) err_query = 1'b0;
            @(negedge core_clk);
            check(err_read, (i < 9) ? 16'(i + 1) : 16'hFEA2);
        end
        $display("test error queue done");
        @(negedge core_clk) opc_cmd = 1'b1;
        @(negedge core_clk) opc_cmd = 1'b0;
        repeat (5) @(negedge core_clk);
        check(opc_busy, 1'b1);
        query(2, d); check(d, 8'h00);
        repeat (25) @(negedge core_clk);
        query(2, d); check(d, 8'h01);
        // The query form queues an ASCII one; popping it drops message available.
        @(negedge core_clk) opc_query = 1'b1;
        @(negedge core_clk) opc_query = 1'b0;
        repeat (25) @(negedge core_clk);
        check(resp_head, 8'h31);
        query(0, d); check(d, sbyte(0, 1, 0, 1));
        @(negedge core_clk) resp_pop = 1'b1;
        @(negedge core_clk) resp_pop = 1'b0;
        query(0, d); check(d, 8'h00);
        check(resp_avail, 1'b0);
        $display("test operation complete done");
        // Fill the input queue with random bytes until it refuses.
        for (int i = 0; i < 100; i++) begin
            @(negedge core_clk) in_byte_valid = 1'b1;
            seed = lfsr(seed);
            in_byte = seed;
        end
        @(negedge core_clk) in_byte_valid = 1'b0;
        @(negedge core_clk); check(in_ready, 1'b0);
        @(negedge core_clk) in_byte_pop = 1'b1;
        @(negedge core_clk) in_byte_pop = 1'b0;
        @(negedge core_clk); check(in_ready, 1'b1);
        $display("test input queue done");
        give_verdict();
    end
endmodule : status_reporting_bench
